/* File: cmd_diag.sv */
// command mode entry and exit plus diagnostic status registers
// How it works
// - integrity error count saturates at ffff
// - good frame count saturates at ffff
// - retry exhausted count saturates at ffff
// - ack failure counter plus one each
// - signal output held for programmed tenths
// - last packet level as negative dbm
// - duty cycle usage reported as percent
// - last reset cause code recorded
// - read only firmware and hardware versions
// - config code derived from current settings
// - signed temperature clamped to limits
// - supply voltage reported in millivolts
// - channel signal level reported on request
// - inactivity timeout returns to idle
// - exit request leaves command mode immediately
// - guard silence required before and after
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module cmd_diag
  import cmd_diag_pkg::*;
#(
  parameter logic [31:0] FIRMWARE_VERSION = 32'h0000_0001,  // arbitrary value
  parameter logic [15:0] HARDWARE_VERSION = 16'h0001,       // arbitrary value
  parameter int          TENTH_CYCLES     = TENTH_CYC,
  parameter int          MS_CYCLES        = MS_CYC
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // register port
  input  wire logic [ADDR_W-1:0]     addr,
  input  wire logic [DATA_W-1:0]     wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic [DATA_W-1:0]          rdata,
  // serial receive bytes and radio events, same clock
  input  cmd_diag_pkg::ser_byte_t    ser_in,
  input  wire logic                  valid_command,
  input  cmd_diag_pkg::radio_events_t events,
  input  cmd_diag_pkg::monitor_t     monitor,
  // reset cause, sampled after reset release
  input  cmd_diag_pkg::reset_cause_t reset_cause_in,
  // mode and signal strength outputs
  output logic                       command_mode,
  output logic                       signal_strength_active
);
  import cmd_diag_pkg::*;

  // elaboration refuses divisors too small for the tick generators
  if (TENTH_CYCLES < 2 || MS_CYCLES < 2) begin : g_div_check
    $error("cmd_diag: tick divisors below 2");
  end

  // escape detector states
  typedef enum logic [1:0] {
    ESC_WAIT_PRE   = 2'b00,  // collecting leading silence
    ESC_COLLECT    = 2'b01,  // counting escape characters
    ESC_WAIT_POST  = 2'b10   // collecting trailing silence
  } esc_state_t;

  // software visible settings
  logic [7:0]  hold_time_reg;       // tenths of a second
  logic [15:0] inact_timeout_reg;   // milliseconds
  logic [15:0] guard_time_reg;      // milliseconds
  logic [7:0]  escape_char_reg;
  reset_cause_t reset_cause_reg;
  logic        cause_taken_reg;     // cause captured once after release

  // counters
  logic [15:0] rx_err_count, good_count, tx_exh_count, ack_fail_count;

  // time bases
  logic ms_tick, tenth_tick;

  // escape sequence state
  esc_state_t  esc_state_reg;
  logic [15:0] silence_reg;         // ms of silence seen
  logic [1:0]  esc_count_reg;       // escape chars collected
  logic        seq_done;

  // command mode timing
  logic [15:0] inact_reg;
  logic        exit_req;

  // hold timer
  logic [7:0]  hold_reg;

  // register write decode
  logic wr_hold, wr_inact, wr_guard, wr_esc, wr_ack_clr;
  assign wr_hold    = wr && addr == OFF_SIG_HOLD_TIME;
  assign wr_inact   = wr && addr == OFF_INACT_TIMEOUT;
  assign wr_guard   = wr && addr == OFF_GUARD_TIME;
  assign wr_esc     = wr && addr == OFF_ESCAPE_CHAR;
  assign wr_ack_clr = wr && addr == OFF_ACK_FAILURE;
  assign exit_req   = wr && addr == OFF_EXIT_REQUEST;

  // event counters, all start at zero
  sat_counter u_rx_err (
    .clk   (clk),
    .rst   (rst),
    .hit   (events.rx_integrity_err),
    .clear (1'b0),
    .count (rx_err_count)
  );
  sat_counter u_good (
    .clk   (clk),
    .rst   (rst),
    .hit   (events.good_frame),
    .clear (1'b0),
    .count (good_count)
  );
  sat_counter u_tx_exh (
    .clk   (clk),
    .rst   (rst),
    .hit   (events.tx_retry_exhausted),
    .clear (1'b0),
    .count (tx_exh_count)
  );
  // ack counter is writable to zero; a clear in an event cycle is dropped and the event counted
  sat_counter u_ack (
    .clk   (clk),
    .rst   (rst),
    .hit   (events.ack_failure),
    .clear (wr_ack_clr && !events.ack_failure),
    .count (ack_fail_count)
  );

  // millisecond and tenth second bases
  tick_gen #(.DIV(MS_CYCLES)) u_ms (
    .clk     (clk),
    .rst     (rst),
    .restart (1'b0),
    .tick    (ms_tick)
  );
  tick_gen #(.DIV(TENTH_CYCLES)) u_tenth (
    .clk     (clk),
    .rst     (rst),
    .restart (events.packet_received),
    .tick    (tenth_tick)
  );

  // settings; out of range writes are clamped into range
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_time_reg     <= HOLD_TIME_RST;
      inact_timeout_reg <= INACT_RST;
      guard_time_reg    <= GUARD_RST;
      escape_char_reg   <= ESC_CHAR_RST;
    end else begin
      if (wr_hold) begin
        // zero would keep the output high with no end; floor at one tenth
        hold_time_reg <= (wdata[7:0] < HOLD_TIME_MIN) ? HOLD_TIME_MIN : wdata[7:0];
      end
      if (wr_inact) begin
        if (wdata[15:0] < INACT_MIN) inact_timeout_reg <= INACT_MIN;
        else if (wdata[15:0] > INACT_MAX) inact_timeout_reg <= INACT_MAX;
        else inact_timeout_reg <= wdata[15:0];
      end
      if (wr_guard) guard_time_reg <= wdata[15:0];
      if (wr_esc) escape_char_reg <= wdata[7:0];
    end
  end

  // reset cause caught by a clocked process after release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_cause_reg <= CAUSE_POWER;
      cause_taken_reg <= 1'b0;
    end else if (!cause_taken_reg) begin
      reset_cause_reg <= reset_cause_in;
      cause_taken_reg <= 1'b1;
    end
  end

  // escape detector; only meaningful while idle
  assign seq_done = esc_state_reg == ESC_WAIT_POST && silence_reg >= guard_time_reg
                    && !ser_in.valid;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      esc_state_reg <= ESC_WAIT_PRE;
      silence_reg   <= 16'h0000;
      esc_count_reg <= 2'b00;
    end else if (command_mode) begin
      esc_state_reg <= ESC_WAIT_PRE;
      silence_reg   <= 16'h0000;
      esc_count_reg <= 2'b00;
    end else begin
      unique case (esc_state_reg)
        ESC_WAIT_PRE: begin
          if (ser_in.valid) begin
            // a char after enough silence may start the sequence
            if (ser_in.data == escape_char_reg && silence_reg >= guard_time_reg) begin
              esc_state_reg <= ESC_COLLECT;
              esc_count_reg <= 2'b01;
            end
            silence_reg <= 16'h0000;
          end else if (ms_tick && silence_reg != CNT_MAX) begin
            silence_reg <= silence_reg + 16'h0001;
          end
        end
        ESC_COLLECT: begin
          if (ser_in.valid) begin
            if (ser_in.data == escape_char_reg) begin
              if (esc_count_reg == 2'(ESC_COUNT - 1)) esc_state_reg <= ESC_WAIT_POST;
              esc_count_reg <= esc_count_reg + 2'b01;
            end else begin
              esc_state_reg <= ESC_WAIT_PRE;
              esc_count_reg <= 2'b00;
            end
            silence_reg <= 16'h0000;
          end
        end
        ESC_WAIT_POST: begin
          if (ser_in.valid) begin
            esc_state_reg <= ESC_WAIT_PRE;
            esc_count_reg <= 2'b00;
            silence_reg   <= 16'h0000;
          end else if (seq_done) begin
            esc_state_reg <= ESC_WAIT_PRE;
            silence_reg   <= 16'h0000;
          end else if (ms_tick) begin
            silence_reg <= silence_reg + 16'h0001;
          end
        end
        default: begin
          esc_state_reg <= ESC_WAIT_PRE;
        end
      endcase
    end
  end

  // mode: enter on sequence, leave on timeout or exit request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      command_mode <= 1'b0;
      inact_reg    <= 16'h0000;
    end else if (!command_mode) begin
      inact_reg <= 16'h0000;
      if (seq_done) command_mode <= 1'b1;
    end else if (exit_req) begin
      command_mode <= 1'b0;
    end else if (valid_command) begin
      inact_reg <= 16'h0000;
    end else if (ms_tick) begin
      if (inact_reg + 16'h0001 >= inact_timeout_reg) begin
        command_mode <= 1'b0;
      end
      inact_reg <= inact_reg + 16'h0001;
    end
  end

  // signal strength hold timer, reloaded on every reception
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_reg               <= 8'h00;
      signal_strength_active <= 1'b0;
    end else if (events.packet_received) begin
      hold_reg               <= hold_time_reg;
      signal_strength_active <= 1'b1;
    end else if (tenth_tick && hold_reg != 8'h00) begin
      hold_reg               <= hold_reg - 8'h01;
      signal_strength_active <= hold_reg != 8'h01;
    end
  end

  // temperature clamp to the signed reporting range
  function automatic logic [15:0] clamp_temp(input logic [15:0] t);
    if ($signed(t) < $signed(TEMP_MIN)) clamp_temp = TEMP_MIN;
    else if ($signed(t) > $signed(TEMP_MAX)) clamp_temp = TEMP_MAX;
    else clamp_temp = t;
  endfunction

  // config code folds all settings into one word
  function automatic logic [31:0] config_code(input logic [7:0] h, input logic [15:0] c,
                                              input logic [15:0] g, input logic [7:0] e);
    config_code = {h, e, 16'h0000} ^ {c, g};
  endfunction

  // read mux; unmapped offsets return zero, data valid one cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        OFF_FIRMWARE_VERSION: rdata <= FIRMWARE_VERSION;
        OFF_HARDWARE_VERSION: rdata <= {16'h0000, HARDWARE_VERSION};
        OFF_CONFIG_CODE:      rdata <= config_code(hold_time_reg, inact_timeout_reg,
                                                   guard_time_reg, escape_char_reg);
        OFF_RX_INTEGRITY_ERR: rdata <= {16'h0000, rx_err_count};
        OFF_GOOD_FRAME:       rdata <= {16'h0000, good_count};
        OFF_SIG_HOLD_TIME:    rdata <= {24'h000000, hold_time_reg};
        OFF_TX_RETRY_EXH:     rdata <= {16'h0000, tx_exh_count};
        OFF_TEMPERATURE:      rdata <= {16'h0000, clamp_temp(monitor.temperature)};
        OFF_LAST_PKT_LEVEL:   rdata <= {24'h000000, monitor.last_pkt_level};
        OFF_DUTY_CYCLE:       rdata <= {24'h000000, monitor.duty_cycle};
        OFF_CHANNEL_LEVEL:    rdata <= {24'h000000, monitor.channel_level};
        OFF_RESET_CAUSE:      rdata <= {29'h00000000, reset_cause_reg};
        OFF_ACK_FAILURE:      rdata <= {16'h0000, ack_fail_count};
        OFF_SUPPLY_MV:        rdata <= {16'h0000, monitor.supply_mv};
        OFF_INACT_TIMEOUT:    rdata <= {16'h0000, inact_timeout_reg};
        OFF_GUARD_TIME:       rdata <= {16'h0000, guard_time_reg};
        OFF_ESCAPE_CHAR:      rdata <= {24'h000000, escape_char_reg};
        OFF_MODE_STATUS:      rdata <= {29'h00000000, esc_state_reg, command_mode};
        default:              rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule

/* File: cmd_diag_assertions.sv */
// port level checks for the command mode diagnostics block
`timescale 1ns/100ps
module cmd_diag_assertions
  import cmd_diag_pkg::*;
#(
  parameter logic [31:0] FIRMWARE_VERSION = 32'h0000_0001,  // arbitrary value
  parameter logic [15:0] HARDWARE_VERSION = 16'h0001,       // arbitrary value
  parameter int          TENTH_CYCLES     = TENTH_CYC,
  parameter int          MS_CYCLES        = MS_CYC
) (
  // clock and reset
  input wire logic           clk,
  input wire logic           rst,
  // register port
  input wire logic [7:0]     addr,
  input wire logic [31:0]    wdata,
  input wire logic           wr,
  input wire logic           rd,
  input wire logic [31:0]    rdata,
  // serial, events, monitor
  input ser_byte_t           ser_in,
  input wire logic           valid_command,
  input radio_events_t       events,
  input monitor_t            monitor,
  input reset_cause_t        reset_cause_in,
  // outputs
  input wire logic           command_mode,
  input wire logic           signal_strength_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic       armed_reg;  // high until the cause code is taken
  logic [2:0] cause_reg;  // cause code seen after release

  // capture the cause on the first edge after release, as the block does
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_reg <= 1'b1;
      cause_reg <= 3'h0;
    end else if (armed_reg) begin
      armed_reg <= 1'b0;
      cause_reg <= reset_cause_in;
    end
  end

  chk_rdata_quiet: assert property (
    !$past(rd) |-> rdata == 32'h0) else $error("read data outside read slot");
  chk_exit_drops: assert property (
    wr && addr == OFF_EXIT_REQUEST |=> !command_mode) else $error("exit request ignored");
  chk_entry_quiet: assert property (
    $rose(command_mode) |-> !$past(ser_in.valid) && !$past(wr && addr == OFF_EXIT_REQUEST))
    else $error("entry without trailing silence");
  chk_hold_starts: assert property (
    events.packet_received |=> signal_strength_active [*8]) else $error("hold not held");
  chk_hold_drop: assert property (
    $fell(signal_strength_active) |-> !$past(events.packet_received))
    else $error("hold dropped on packet");
  chk_fw_read: assert property (
    rd && addr == OFF_FIRMWARE_VERSION |=> rdata == FIRMWARE_VERSION)
    else $error("firmware version wrong");
  chk_hw_read: assert property (
    rd && addr == OFF_HARDWARE_VERSION |=> rdata == {16'h0, HARDWARE_VERSION})
    else $error("hardware version wrong");
  chk_cause_read: assert property (
    rd && addr == OFF_RESET_CAUSE && !armed_reg |=> rdata == {29'h0, cause_reg})
    else $error("reset cause wrong");
  chk_supply_read: assert property (
    rd && addr == OFF_SUPPLY_MV |=> rdata[15:0] == $past(monitor.supply_mv))
    else $error("supply reading wrong");
  chk_level_read: assert property (
    rd && addr == OFF_LAST_PKT_LEVEL |=> rdata[7:0] == $past(monitor.last_pkt_level))
    else $error("packet level wrong");
  chk_temp_range: assert property (
    rd && addr == OFF_TEMPERATURE |=> $signed(rdata[15:0]) >= $signed(TEMP_MIN)
    && $signed(rdata[15:0]) <= $signed(TEMP_MAX)) else $error("temperature out of range");

  // main scenarios reached
  cov_entry: cover property ($rose(command_mode));
  cov_leave: cover property ($fell(command_mode));
  cov_hold_end: cover property ($fell(signal_strength_active));
endmodule

/* File: cmd_diag_pkg.sv */
// shared constants, types and register map for the command-mode diagnostics block
package cmd_diag_pkg;

  // register bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register offsets (word index on the plain port)
  localparam logic [7:0] OFF_FIRMWARE_VERSION  = 8'h00;
  localparam logic [7:0] OFF_HARDWARE_VERSION  = 8'h01;
  localparam logic [7:0] OFF_CONFIG_CODE       = 8'h02;
  localparam logic [7:0] OFF_RX_INTEGRITY_ERR  = 8'h03;
  localparam logic [7:0] OFF_GOOD_FRAME        = 8'h04;
  localparam logic [7:0] OFF_SIG_HOLD_TIME     = 8'h05;
  localparam logic [7:0] OFF_TX_RETRY_EXH      = 8'h06;
  localparam logic [7:0] OFF_TEMPERATURE       = 8'h07;
  localparam logic [7:0] OFF_LAST_PKT_LEVEL    = 8'h08;
  localparam logic [7:0] OFF_DUTY_CYCLE        = 8'h09;
  localparam logic [7:0] OFF_CHANNEL_LEVEL     = 8'h0a;
  localparam logic [7:0] OFF_RESET_CAUSE       = 8'h0b;
  localparam logic [7:0] OFF_ACK_FAILURE       = 8'h0c;
  localparam logic [7:0] OFF_SUPPLY_MV         = 8'h0d;
  localparam logic [7:0] OFF_INACT_TIMEOUT     = 8'h0e;
  localparam logic [7:0] OFF_EXIT_REQUEST      = 8'h0f;
  localparam logic [7:0] OFF_GUARD_TIME        = 8'h10;
  localparam logic [7:0] OFF_ESCAPE_CHAR       = 8'h11;
  localparam logic [7:0] OFF_MODE_STATUS       = 8'h12;

  // reset values and limits
  localparam logic [15:0] CNT_MAX              = 16'hffff;
  localparam logic [7:0]  HOLD_TIME_RST        = 8'h20;
  localparam logic [7:0]  HOLD_TIME_MIN        = 8'h01;
  localparam logic [15:0] INACT_RST            = 16'h0064;
  localparam logic [15:0] INACT_MIN            = 16'h0002;
  localparam logic [15:0] INACT_MAX            = 16'h1770;
  localparam logic [15:0] GUARD_RST            = 16'h03e8;
  localparam logic [7:0]  ESC_CHAR_RST         = 8'h2b;
  localparam logic [15:0] TEMP_MIN             = 16'hff74;
  localparam logic [15:0] TEMP_MAX             = 16'h0258;
  localparam int          ESC_COUNT            = 3;

  // timing: clock rate and time bases
  localparam int CLK_HZ     = 25_000_000;
  localparam int TENTH_S_NS = 100_000_000;   // hold unit, 100 ms
  localparam int MS_NS      = 1_000_000;     // guard and inactivity unit, 1 ms
  localparam int CLK_NS     = 1_000_000_000 / CLK_HZ;
  localparam int TENTH_CYC  = TENTH_S_NS / CLK_NS;
  localparam int MS_CYC     = MS_NS / CLK_NS;

  // reset cause codes
  typedef enum logic [2:0] {
    CAUSE_POWER    = 3'h0,
    CAUSE_WATCHDOG = 3'h2,
    CAUSE_SOFTWARE = 3'h3,
    CAUSE_LINE     = 3'h4,
    CAUSE_BROWNOUT = 3'h5
  } reset_cause_t;

  // radio link events, all one-cycle pulses from link logic
  typedef struct packed {
    logic rx_integrity_err;
    logic good_frame;
    logic tx_retry_exhausted;
    logic ack_failure;
    logic packet_received;
  } radio_events_t;

  // analog and monitor readings from same-clock logic
  typedef struct packed {
    logic [15:0] temperature;
    logic [15:0] supply_mv;
    logic [7:0]  last_pkt_level;
    logic [7:0]  channel_level;
    logic [7:0]  duty_cycle;
  } monitor_t;

  // serial byte from the receive uart
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ser_byte_t;

  // saturating 16 bit increment, shared by all counters
  function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic hit);
    sat_inc = (hit && v != CNT_MAX) ? v + 16'h0001 : v;
  endfunction

endpackage

/* File: host_model.sv */
// host side model: sends serial bytes and keeps guard silences
`timescale 1ns/100ps
module host_model
  import cmd_diag_pkg::*;
(
  // clock
  input  wire logic clk,
  // received byte towards the block
  output ser_byte_t ser_out
);
  // line idle with no byte flagged
  initial ser_out = '0;

  // one byte, one cycle valid; data then flips so stale data is never mistaken
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk);
    ser_out <= '{valid: 1'b1, data: b};
    @(posedge clk);
    ser_out <= '{valid: 1'b0, data: ~b};
  endtask

  // silence on the line for a number of cycles
  task automatic quiet(input int cyc);
    repeat (cyc) @(posedge clk);
  endtask

  // guarded entry sequence: silence, three escape bytes, silence
  task automatic escape(input logic [7:0] ch, input int gap);
    quiet(gap);
    repeat (3) send_byte(ch);
    quiet(gap);
  endtask
endmodule

/* File: sat_counter.sv */
// saturating event counter with synchronous clear
`timescale 1ns/100ps
module sat_counter (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // event and clear
  input  wire logic        hit,
  input  wire logic        clear,
  // count
  output logic [15:0]      count
);
  import cmd_diag_pkg::*;

  // count holds at all ones, never wraps
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 16'h0000;
    end else if (clear) begin
      count <= 16'h0000;
    end else begin
      count <= sat_inc(count, hit);
    end
  end
endmodule

/* File: tb_top.sv */
// top testbench for the command mode diagnostics block
`timescale 1ns/100ps
module tb_top;
  import cmd_diag_pkg::*;
  localparam int          MS    = 4;              // shortened millisecond
  localparam int          TENTH = 20;             // shortened tenth second
  localparam logic [31:0] FW    = 32'h0000_0a17;  // arbitrary value
  localparam logic [15:0] HW    = 16'h0c3d;       // arbitrary value
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic [7:0]    addr;
  logic [31:0]   wdata;
  logic          wr;
  logic          rd;
  logic [31:0]   rdata;
  ser_byte_t     ser_in;
  logic          valid_command;
  radio_events_t events;
  monitor_t      monitor;
  reset_cause_t  cause;
  logic          command_mode;
  logic          sig_active;
  int            fail_count = 0;
  int            num_checks = 0;
  logic [7:0]    cnt_offs [4] = '{OFF_RX_INTEGRITY_ERR, OFF_GOOD_FRAME, OFF_TX_RETRY_EXH,
                                  OFF_ACK_FAILURE};

  // 25 MHz clock
  always #20 clk = ~clk;

  host_model host (.clk(clk), .ser_out(ser_in));
  cmd_diag #(.FIRMWARE_VERSION(FW), .HARDWARE_VERSION(HW), .TENTH_CYCLES(TENTH),
             .MS_CYCLES(MS)) uut (
    .clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .ser_in, .valid_command, .events, .monitor,
    .reset_cause_in(cause), .command_mode, .signal_strength_active(sig_active));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bus tasks start and end just after a rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
    @(posedge clk);
  endtask

  // sel picks the hold output, else the mode output
  task automatic chk_out(input bit sel, input logic [31:0] e);
    #1 chk({31'h0, sel ? sig_active : command_mode}, e);
    @(posedge clk);
  endtask

  task automatic wait_for(input bit sel, input logic v, input int n);
    int i;
    for (i = 0; i < n && (sel ? sig_active : command_mode) !== v; i++) @(posedge clk) #1;
    if ((sel ? sig_active : command_mode) !== v) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, ~v, v);
      report_and_stop();
    end
    @(posedge clk);
  endtask

  task automatic t_reset;
    rd_chk(OFF_SIG_HOLD_TIME, {24'h0, HOLD_TIME_RST});
    rd_chk(OFF_INACT_TIMEOUT, {16'h0, INACT_RST});
    rd_chk(OFF_GUARD_TIME, {16'h0, GUARD_RST});
    rd_chk(OFF_ESCAPE_CHAR, {24'h0, ESC_CHAR_RST});
    foreach (cnt_offs[i]) rd_chk(cnt_offs[i], 32'h0);
    rd_chk(OFF_RESET_CAUSE, 32'h5);
    wr_reg(OFF_FIRMWARE_VERSION, 32'h1234_5678);
    rd_chk(OFF_FIRMWARE_VERSION, FW);
    rd_chk(OFF_HARDWARE_VERSION, {16'h0, HW});
    rd_chk(8'h20, 32'h0);
    $display("test reset values done");
  endtask

  task automatic t_monitor;
    monitor <= '{16'hfe00, 16'h0ce4, 8'h60, 8'h50, 8'h14};
    @(posedge clk);
    rd_chk(OFF_TEMPERATURE, 32'hff74, 32'hffff);
    rd_chk(OFF_SUPPLY_MV, 32'h0ce4);
    rd_chk(OFF_LAST_PKT_LEVEL, 32'h60);
    rd_chk(OFF_CHANNEL_LEVEL, 32'h50);
    rd_chk(OFF_DUTY_CYCLE, 32'h14);
    monitor.temperature <= 16'h0300;
    @(posedge clk);
    rd_chk(OFF_TEMPERATURE, 32'h0258, 32'hffff);
    rd_chk(OFF_CONFIG_CODE, {HOLD_TIME_RST, ESC_CHAR_RST, 16'h0} ^ {INACT_RST, GUARD_RST});
    $display("test monitor done");
  endtask

  task automatic t_escape;
    wr_reg(OFF_GUARD_TIME, 32'h2);
    wr_reg(OFF_ESCAPE_CHAR, 32'h7e);
    host.escape(8'h2b, 16);
    chk_out(1'b0, 32'h0);
    host.quiet(16);
    host.send_byte(8'h7e);
    host.send_byte(8'h7e);
    host.send_byte(8'h41);
    host.send_byte(8'h7e);
    host.quiet(24);
    chk_out(1'b0, 32'h0);
    host.send_byte(8'h41);
    host.escape(8'h7e, 0);
    host.quiet(24);
    chk_out(1'b0, 32'h0);
    // good leading silence, but a stray byte inside the trailing one
    host.quiet(16);
    repeat (3) host.send_byte(8'h7e);
    host.send_byte(8'h41);
    host.quiet(24);
    chk_out(1'b0, 32'h0);
    host.escape(8'h7e, 16);
    wait_for(1'b0, 1'b1, 20);
    rd_chk(OFF_MODE_STATUS, 32'h1);
    wr_reg(OFF_EXIT_REQUEST, 32'h0);
    chk_out(1'b0, 32'h0);
    $display("test escape done");
  endtask

  task automatic t_timeout;
    wr_reg(OFF_INACT_TIMEOUT, 32'h1);
    rd_chk(OFF_INACT_TIMEOUT, 32'h2);
    wr_reg(OFF_INACT_TIMEOUT, 32'hffff);
    rd_chk(OFF_INACT_TIMEOUT, 32'h1770);
    wr_reg(OFF_INACT_TIMEOUT, 32'h5);
    host.escape(8'h7e, 16);
    wait_for(1'b0, 1'b1, 20);
    // commands spaced under the period keep the mode alive
    repeat (4) begin
      valid_command <= 1'b1;
      @(posedge clk);
      valid_command <= 1'b0;
      repeat (12) @(posedge clk);
    end
    chk_out(1'b0, 32'h1);
    wait_for(1'b0, 1'b0, 20);
    $display("test timeout done");
  endtask

  task automatic t_hold;
    chk_out(1'b1, 32'h0);
    wr_reg(OFF_SIG_HOLD_TIME, 32'h0);
    rd_chk(OFF_SIG_HOLD_TIME, 32'h1);
    events <= radio_events_t'(5'h01);
    @(posedge clk);
    events <= '0;
    repeat (10) @(posedge clk);
    chk_out(1'b1, 32'h1);
    wait_for(1'b1, 1'b0, 40);
    $display("test hold done");
  endtask

  task automatic t_counters;
    repeat (3) begin
      events <= radio_events_t'(5'h1e);
      @(posedge clk);
      events <= '0;
      @(posedge clk);
    end
    foreach (cnt_offs[i]) rd_chk(cnt_offs[i], 32'h3);
    // a long burst drives every counter past its top
    events <= radio_events_t'(5'h1e);
    repeat (65540) @(posedge clk);
    events <= '0;
    @(posedge clk);
    foreach (cnt_offs[i]) rd_chk(cnt_offs[i], 32'hffff);
    wr_reg(OFF_ACK_FAILURE, 32'h0);
    rd_chk(OFF_ACK_FAILURE, 32'h0);
    $display("test counters done");
  endtask

  // mid-run reset with a new cause: settings, counters and cause restart
  task automatic t_rerst;
    cause <= CAUSE_WATCHDOG;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(OFF_RESET_CAUSE, 32'h2);
    rd_chk(OFF_SIG_HOLD_TIME, {24'h0, HOLD_TIME_RST});
    foreach (cnt_offs[i]) rd_chk(cnt_offs[i], 32'h0);
    chk_out(1'b0, 32'h0);
    $display("test mid-run reset done");
  endtask

  // reset for two cycles, then the scenarios in turn
  initial begin
    addr = 8'h00;
    wdata = 32'h0;
    {wr, rd, valid_command} = 3'b000;
    events = '0;
    monitor = '0;
    cause = CAUSE_BROWNOUT;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_monitor();
    t_escape();
    t_timeout();
    t_hold();
    t_counters();
    t_rerst();
    report_and_stop();
  end
endmodule

bind cmd_diag cmd_diag_assertions #(
  .FIRMWARE_VERSION(FIRMWARE_VERSION), .HARDWARE_VERSION(HARDWARE_VERSION),
  .TENTH_CYCLES(TENTH_CYCLES), .MS_CYCLES(MS_CYCLES)) chk_inst (
  .clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .ser_in, .valid_command, .events, .monitor,
  .reset_cause_in, .command_mode, .signal_strength_active);

/* File: tick_gen.sv */
// tick generator dividing clk into a fixed time base, restarted from zero by restart
`timescale 1ns/100ps
module tick_gen #(
  parameter int DIV = 25_000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // restart and tick
  input  wire logic restart,
  output logic      tick
);
  localparam int W = $clog2(DIV + 1);
  logic [W-1:0] cnt_reg;

  // a divisor below two cannot make a one cycle tick with a gap
  if (DIV < 2) begin : g_div_check
    $error("tick_gen: DIV must be at least 2");
  end

  // restart lets a time window start cleanly on an event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (restart) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (cnt_reg == W'(DIV - 1)) begin
      cnt_reg <= '0;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + W'(1);
      tick    <= 1'b0;
    end
  end
endmodule
